// >>> dsb_pkg.sv
// package for the software key and boost control register decode
// assumes a 50 MHz system clock standing in for the internal oscillator
package dsb_pkg;
  // ----------------------------------------
  // payload decode
  // ----------------------------------------
  localparam logic [2:0] SEL_SOFTWARE = 3'h4;
  localparam logic [2:0] SEL_BOOST = 3'h3;
  localparam int SEL_HI = 15;
  localparam int SEL_LO = 13;
  localparam int PEC_BIT = 12;
  localparam int KEY_HI = 11;
  localparam logic [11:0] KEY_RESET = 12'h555;
  localparam logic [11:0] KEY_SERVICE = 12'h195;
  localparam int COMP_BIT = 6;
  localparam int SKEW_HI = 5;
  localparam int SKEW_LO = 4;
  localparam int RATE_HI = 3;
  localparam int RATE_LO = 2;
  localparam int CEIL_HI = 1;
  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [1:0] RATE_250K = 2'h0;
  localparam logic [1:0] RATE_410K = 2'h1;
  localparam logic [1:0] RATE_650K = 2'h2;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  localparam logic [1:0] SKEW_SAME = 2'h0;
  localparam logic [1:0] SKEW_AB_CD = 2'h1;
  localparam logic [1:0] SKEW_AC_BD = 2'h2;
  localparam logic [1:0] SKEW_QUAD = 2'h3;
  localparam logic RST_COMP = 1'b0;
  localparam logic [1:0] RST_SKEW = SKEW_SAME;
  localparam logic [1:0] RST_RATE = RATE_410K;
  localparam logic [1:0] RST_CEIL = 2'h0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int F250_HZ = 250_000;
  localparam int F410_HZ = 410_000;
  localparam int F650_HZ = 650_000;
  // quarter period of the switching clock (one phase step), in clock cycles (rounded down)
  localparam int DIV250 = CLK_HZ / (F250_HZ * 4);
  localparam int DIV410 = CLK_HZ / (F410_HZ * 4);
  localparam int DIV650 = CLK_HZ / (F650_HZ * 4);
  localparam int DIV_W = 8;
  localparam int WDOG_W = 32;
endpackage

// >>> dsb_ctrl.sv
// software key register and boost converter control register decode
// assumes the serial front end hands over one 16-bit payload per strobe,
// synchronous to clock_i; watchdog enable and timeout come from elsewhere
// the switching clocks are divided from clock_i, so rates are approximate
`timescale 1ns/100ps
module dsb_ctrl #(
  parameter logic [31:0] WDOG_DEF = 32'h0001_0000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_stb_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wdog_en_i,
  input wire logic [31:0] wdog_limit_i,
  output logic packet_check_on_o,
  output logic soft_reset_o,
  output logic alert_o,
  output logic boost_comp_select_o,
  output logic [1:0] boost_clock_skew_sel_o,
  output logic [1:0] boost_switch_rate_sel_o,
  output logic [1:0] boost_ceiling_sel_o,
  output logic [3:0] boost_clk_o,
  output logic [15:0] boost_rd_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic pec;
    logic srst;
    logic alert;
    logic comp;
    logic [1:0] skew;
    logic [1:0] rate;
    logic [1:0] ceil;
    logic [31:0] wdog;
    logic [7:0] div;
    logic [1:0] phase;
    logic [3:0] clk;
  } dsb_state_t;

  dsb_state_t st_r;
  dsb_state_t st_nxt;

  function automatic logic [7:0] div_of(input logic [1:0] rate);
    case (rate)
      dsb_pkg::RATE_250K: div_of = 8'(dsb_pkg::DIV250 - 1);
      dsb_pkg::RATE_650K: div_of = 8'(dsb_pkg::DIV650 - 1);
      default: div_of = 8'(dsb_pkg::DIV410 - 1);
    endcase
  endfunction

  // per-channel clock from a four-step phase; quad step 0..3 is 90 degrees
  function automatic logic [3:0] clk_of(input logic [1:0] skew,
                                        input logic [1:0] ph);
    logic h;
    h = ph[1];
    case (skew)
      dsb_pkg::SKEW_SAME: clk_of = {h, h, h, h};
      dsb_pkg::SKEW_AB_CD: clk_of = {~h, ~h, h, h};
      dsb_pkg::SKEW_AC_BD: clk_of = {~h, h, ~h, h};
      default: clk_of = {ph == 2'h1 || ph == 2'h2, ph[1],
                         ph == 2'h3 || ph == 2'h0, ~ph[1]};
    endcase
  endfunction

  logic [2:0] sel;
  logic [11:0] key;
  logic sw_wr;
  logic bst_wr;
  assign sel = wr_data_i[dsb_pkg::SEL_HI:dsb_pkg::SEL_LO];
  assign key = wr_data_i[dsb_pkg::KEY_HI:0];
  assign sw_wr = wr_stb_i && sel == dsb_pkg::SEL_SOFTWARE;
  assign bst_wr = wr_stb_i && sel == dsb_pkg::SEL_BOOST;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.srst = 1'b0;
    if (sw_wr) begin
      st_nxt.pec = wr_data_i[dsb_pkg::PEC_BIT];
    end
    if (bst_wr) begin
      // bits 12..7 are don't care and never read
      st_nxt.comp = wr_data_i[dsb_pkg::COMP_BIT];
      st_nxt.skew = wr_data_i[dsb_pkg::SKEW_HI:dsb_pkg::SKEW_LO];
      st_nxt.ceil = wr_data_i[dsb_pkg::CEIL_HI:0];
      if (wr_data_i[dsb_pkg::RATE_HI:dsb_pkg::RATE_LO]
          != dsb_pkg::RATE_RSVD) begin
        st_nxt.rate = wr_data_i[dsb_pkg::RATE_HI:dsb_pkg::RATE_LO];
      end
    end
    // watchdog: host must service it in time
    if (!wdog_en_i) begin
      st_nxt.wdog = '0;
      st_nxt.alert = 1'b0;
    end else if (sw_wr && key == dsb_pkg::KEY_SERVICE) begin
      st_nxt.wdog = '0;
    end else if (st_r.wdog >= wdog_limit_i) begin
      st_nxt.alert = 1'b1;
    end else begin
      st_nxt.wdog = st_r.wdog + 32'h1;
    end
    // four-phase switching tick
    if (st_r.div == 8'h0) begin
      st_nxt.div = div_of(st_r.rate);
      st_nxt.phase = st_r.phase + 2'h1;
    end else begin
      st_nxt.div = st_r.div - 8'h1;
    end
    st_nxt.clk = clk_of(st_r.skew, st_r.phase);
    if (sw_wr && key == dsb_pkg::KEY_RESET) begin
      // full reset: all state back to defaults, pulse out to the device
      st_nxt = '0;
      st_nxt.comp = dsb_pkg::RST_COMP;
      st_nxt.skew = dsb_pkg::RST_SKEW;
      st_nxt.rate = dsb_pkg::RST_RATE;
      st_nxt.ceil = dsb_pkg::RST_CEIL;
      st_nxt.srst = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.comp <= dsb_pkg::RST_COMP;
      st_r.skew <= dsb_pkg::RST_SKEW;
      st_r.rate <= dsb_pkg::RST_RATE;
      st_r.ceil <= dsb_pkg::RST_CEIL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign packet_check_on_o = st_r.pec;
  assign soft_reset_o = st_r.srst;
  assign alert_o = st_r.alert;
  assign boost_comp_select_o = st_r.comp;
  assign boost_clock_skew_sel_o = st_r.skew;
  assign boost_switch_rate_sel_o = st_r.rate;
  assign boost_ceiling_sel_o = st_r.ceil;
  assign boost_clk_o = st_r.clk;
  // slew control is per channel in another block
  assign boost_rd_o = {dsb_pkg::SEL_BOOST, 6'h00, st_r.comp, st_r.skew,
                       st_r.rate, st_r.ceil};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // a reset key write throws every field and clock back to defaults, so
  // checks that expect a field or a clock to carry on must exclude it
  logic key_rst_wr;
  assign key_rst_wr = sw_wr && key == dsb_pkg::KEY_RESET;

  AST_PEC: assert property (sw_wr && key != dsb_pkg::KEY_RESET |=>
    packet_check_on_o == $past(wr_data_i[dsb_pkg::PEC_BIT]))
    else $error("packet check bit not taken");
  AST_SRST: assert property (sw_wr && key == dsb_pkg::KEY_RESET |=>
    soft_reset_o && boost_switch_rate_sel_o == dsb_pkg::RST_RATE
    && !packet_check_on_o) else $error("software reset not performed");
  AST_NO_SRST: assert property (soft_reset_o |->
    $past(sw_wr && key == dsb_pkg::KEY_RESET))
    else $error("spurious reset");
  AST_ALERT_OFF: assert property (!wdog_en_i |=> !alert_o)
    else $error("alert with watchdog off");
  AST_ALERT_ON: assert property (wdog_en_i && !alert_o && !sw_wr
    && st_r.wdog >= wdog_limit_i ##1 wdog_en_i && !key_rst_wr |=> alert_o)
    else $error("missed watchdog alert");
  AST_BOOST: assert property (bst_wr |=>
    boost_comp_select_o == $past(wr_data_i[dsb_pkg::COMP_BIT])
    && boost_ceiling_sel_o == $past(wr_data_i[dsb_pkg::CEIL_HI:0]))
    else $error("boost fields not taken");
  AST_RSVD: assert property (bst_wr && wr_data_i[dsb_pkg::RATE_HI:
    dsb_pkg::RATE_LO] == dsb_pkg::RATE_RSVD |=> $stable(st_r.rate))
    else $error("reserved rate applied");
  AST_SAME: assert property (st_r.skew == dsb_pkg::SKEW_SAME
    && $stable(st_r.skew) |=> (&boost_clk_o) || !(|boost_clk_o))
    else $error("channels not on same edge");
  AST_PAIR: assert property (st_r.skew == dsb_pkg::SKEW_AB_CD
    && $stable(st_r.skew) && !key_rst_wr
    |=> boost_clk_o[0] == boost_clk_o[1]
    && boost_clk_o[2] != boost_clk_o[0] && boost_clk_o[3] == boost_clk_o[2])
    else $error("pair skew wrong");
  AST_RATE: assert property (st_r.rate != dsb_pkg::RATE_RSVD)
    else $error("rate register holds reserved code");

  // ----------------------------------------
  // checks: field capture and hold
  // ----------------------------------------
  AST_SKEW: assert property (bst_wr |=>
    boost_clock_skew_sel_o
    == $past(wr_data_i[dsb_pkg::SKEW_HI:dsb_pkg::SKEW_LO]))
    else $error("skew field not taken");
  AST_RATE_TAKEN: assert property (bst_wr
    && wr_data_i[dsb_pkg::RATE_HI:dsb_pkg::RATE_LO] != dsb_pkg::RATE_RSVD
    |=> boost_switch_rate_sel_o
    == $past(wr_data_i[dsb_pkg::RATE_HI:dsb_pkg::RATE_LO]))
    else $error("rate field not taken");
  // a write to some other register, other than a reset key write, must leave every field alone
  AST_PEC_HOLD: assert property (!sw_wr |=>
    $stable(packet_check_on_o))
    else $error("packet check changed without a write");
  AST_BOOST_HOLD: assert property (!bst_wr && !key_rst_wr |=>
    $stable({boost_comp_select_o, boost_clock_skew_sel_o,
    boost_switch_rate_sel_o, boost_ceiling_sel_o}))
    else $error("boost fields changed without a write");
  AST_OTHER_SEL: assert property (wr_stb_i && !sw_wr && !bst_wr
    |=> $stable(boost_rd_o) && $stable(packet_check_on_o)
    && !soft_reset_o)
    else $error("unselected write changed a field");

  // ----------------------------------------
  // checks: software reset
  // ----------------------------------------
  AST_SRST_VAL: assert property (soft_reset_o |->
    boost_clk_o == 4'h0 && !alert_o
    && boost_comp_select_o == dsb_pkg::RST_COMP
    && boost_clock_skew_sel_o == dsb_pkg::RST_SKEW
    && boost_ceiling_sel_o == dsb_pkg::RST_CEIL)
    else $error("reset left a field set");
  AST_SRST_DIV: assert property (soft_reset_o |->
    st_r.div == 8'h0 && st_r.phase == 2'h0 && st_r.wdog == 32'h0)
    else $error("reset left the counters running");
  // the pulse is one cycle unless the host repeats the key at once
  AST_SRST_ONE: assert property (soft_reset_o && !key_rst_wr
    |=> !soft_reset_o)
    else $error("reset pulse too long");

  // ----------------------------------------
  // checks: watchdog
  // ----------------------------------------
  AST_ALERT_EARLY: assert property ($rose(alert_o) |->
    $past(st_r.wdog >= wdog_limit_i))
    else $error("alert before timeout");
  AST_ALERT_HOLD: assert property (alert_o && wdog_en_i
    && !key_rst_wr |=> alert_o)
    else $error("alert dropped while enabled");
  AST_WDOG_RUN: assert property (wdog_en_i && !sw_wr
    && st_r.wdog < wdog_limit_i
    |=> st_r.wdog == $past(st_r.wdog) + 32'h1)
    else $error("watchdog count stalled");
  AST_SERVICE: assert property (wdog_en_i && sw_wr
    && key == dsb_pkg::KEY_SERVICE |=> st_r.wdog == 32'h0)
    else $error("service key did not restart the watchdog");
  // with the watchdog off the count stays parked so enabling starts fresh
  AST_WDOG_OFF: assert property (!wdog_en_i |=>
    st_r.wdog == 32'h0)
    else $error("watchdog counts while disabled");

  // ----------------------------------------
  // checks: switching clocks
  // ----------------------------------------
  AST_ACBD: assert property (st_r.skew == dsb_pkg::SKEW_AC_BD
    && $stable(st_r.skew) && !key_rst_wr
    |=> boost_clk_o[0] == boost_clk_o[2]
    && boost_clk_o[1] != boost_clk_o[0] && boost_clk_o[3] == boost_clk_o[1])
    else $error("cross skew wrong");
  // quad: opposite channels are always apart, neighbours a quarter off
  AST_QUAD: assert property (st_r.skew == dsb_pkg::SKEW_QUAD
    && $stable(st_r.skew) && !key_rst_wr
    |=> boost_clk_o[0] != boost_clk_o[2] && boost_clk_o[1] != boost_clk_o[3])
    else $error("quad skew wrong");
  // the phase may only move when the divider runs out or on a reset key write
  AST_PHASE_HOLD: assert property (st_r.div != 8'h0
    && !key_rst_wr |=> $stable(st_r.phase))
    else $error("phase moved early");
  AST_PHASE_STEP: assert property (st_r.div == 8'h0
    && !key_rst_wr |=> st_r.phase == $past(st_r.phase) + 2'h1)
    else $error("phase did not advance");
  AST_DIV_MAX: assert property (st_r.div < 8'(dsb_pkg::DIV250))
    else $error("divider out of range");

  // ----------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------
  COV_SRST: cover property (soft_reset_o);
  COV_ALERT: cover property (alert_o);
  COV_QUAD: cover property (st_r.skew == dsb_pkg::SKEW_QUAD);
  COV_PAIR: cover property (st_r.skew == dsb_pkg::SKEW_AB_CD);
  COV_RSVD: cover property (bst_wr && wr_data_i[dsb_pkg::RATE_HI:
    dsb_pkg::RATE_LO] == dsb_pkg::RATE_RSVD);
endmodule

// >>> dsb_host.sv
// host model: hands the decode one 16-bit payload per strobe
// assumes the serial framing is already stripped off by a front end
`timescale 1ns/100ps
module dsb_host (
  input wire logic clock_i,
  output logic wr_stb_o,
  output logic [15:0] wr_data_o
);
  initial begin
    wr_stb_o = 1'b0;
    wr_data_o = 16'h0000;
  end
  // -------------------------
  // write cycle
  // -------------------------
  // payload is inverted once released so a stale word is never re-read
  task automatic write(input logic [15:0] d);
    @(posedge clock_i);
    wr_stb_o <= 1'b1;
    wr_data_o <= d;
    @(posedge clock_i);
    wr_stb_o <= 1'b0;
    wr_data_o <= ~d;
  endtask
endmodule

// >>> dac_software_and_boost_control_tb.sv
// bench for the software key and boost control decode
// assumes the host model is the only writer of the payload strobe
`timescale 1ns/100ps
module dac_software_and_boost_control_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wdog_en_i = 1'b0;
  logic [31:0] wdog_limit_i = 32'h0000_0014;
  logic stb;
  logic [15:0] dat;
  logic pec, srst, alert, comp;
  logic [1:0] skew, rate, ceil;
  logic [3:0] bclk;
  logic [15:0] rd;
  int num_errors = 0;
  int samples_checked = 0;
  int ab, ac, rises, n, div;
  initial forever #10 clock_i = ~clock_i;
  dsb_host host (.clock_i(clock_i), .wr_stb_o(stb), .wr_data_o(dat));
  dsb_ctrl DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .wr_stb_i(stb),
    .wr_data_i(dat), .wdog_en_i(wdog_en_i), .wdog_limit_i(wdog_limit_i),
    .packet_check_on_o(pec), .soft_reset_o(srst), .alert_o(alert),
    .boost_comp_select_o(comp), .boost_clock_skew_sel_o(skew),
    .boost_switch_rate_sel_o(rate), .boost_ceiling_sel_o(ceil),
    .boost_clk_o(bclk), .boost_rd_o(rd));
  // -------------------------
  // helpers
  // -------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    host.write(d);
    @(posedge clock_i);
    #1;
  endtask
  function automatic logic [15:0] img(logic c, logic [1:0] s, r, v);
    return {3'h3, 6'h00, c, s, r, v};
  endfunction
  // counts channel mismatches and rising edges of channel a
  task automatic watch(input int len);
    logic last;
    last = bclk[0];
    ab = 0;
    ac = 0;
    rises = 0;
    repeat (len) begin
      @(posedge clock_i);
      #1;
      ab += int'(bclk[0] != bclk[1]);
      ac += int'(bclk[0] != bclk[2]);
      rises += int'(bclk[0] && !last);
      last = bclk[0];
    end
  endtask
  task automatic pulses(input logic [15:0] d);
    host.write(d);
    n = 0;
    repeat (4) begin
      #1;
      n += int'(srst);
      @(posedge clock_i);
    end
    #1;
  endtask
  // -------------------------
  // main sequence
  // -------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check(rd, img(1'b0, 2'h0, 2'h1, 2'h0));
    wr(16'h7fdb);
    check(rd, img(1'b1, 2'h1, 2'h2, 2'h3));
    check({9'h0, comp, skew, rate, ceil}, 16'h005b);
    for (int k = 0; k < 4; k++) begin
      wr(16'h6000 | 16'(k << 4) | 16'(k << 2));
      check({14'h0, rate}, (k == 3) ? 16'h2 : 16'(k));
      watch(800);
      check({14'h0, ab > 0, ac > 0}, 16'(k));
      div = (k == 0) ? dsb_pkg::DIV250 : (k == 1) ? dsb_pkg::DIV410
        : dsb_pkg::DIV650;
      n = 800 / (4 * div) - rises;
      check(16'(n >= -1 && n <= 1), 16'h1);
    end
    wr(16'h9000);
    check({15'h0, pec}, 16'h1);
    pulses(16'h8123);
    check({pec, 15'(n)}, 16'h0);
    check(rd, img(1'b0, 2'h3, 2'h2, 2'h0));
    wr(16'h9000);
    pulses(16'h9555);
    check(16'(n), 16'h1);
    check({pec, rd[14:0]}, img(1'b0, 2'h0, 2'h1, 2'h0));
    @(posedge clock_i);
    wdog_en_i <= 1'b1;
    repeat (6) begin
      host.write(16'h8195);
      repeat (12) @(posedge clock_i);
    end
    #1;
    check({15'h0, alert}, 16'h0);
    host.write(16'h8195);
    n = 0;
    while (!alert && n < 40) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (!alert) begin
      num_errors++;
      test_done();
    end
    check(16'(n >= 18 && n <= 23), 16'h1);
    @(posedge clock_i);
    wdog_en_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    #1;
    check({15'h0, alert}, 16'h0);
    test_done();
  end
endmodule
